//--- hw/flash_frontend_consts.vh
// opcode, region size and buffer constants for the serial flash instruction front end
`ifndef FLASH_FRONTEND_CONSTS_VH
`define FLASH_FRONTEND_CONSTS_VH

`define OP_WRITE_ENABLE 8'h06
`define OP_VOLATILE_WRITE_ENABLE 8'h50
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ_LOW 8'h05
`define OP_STATUS_READ_HIGH 8'h35
`define OP_STATUS_WRITE 8'h01
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_HALF_BLOCK_ERASE 8'h52
`define OP_BLOCK_ERASE 8'hd8
`define OP_CHIP_ERASE_A 8'hc7
`define OP_CHIP_ERASE_B 8'h60
`define OP_READ_DATA 8'h03
`define OP_FAST_READ 8'h0b
`define OP_WAKE_ID 8'hab
`define OP_MAKER_PART_ID 8'h90
`define OP_MAKER_PART_ID_DUAL 8'h92
`define OP_MAKER_PART_ID_QUAD 8'h94
`define OP_LONG_ID 8'h9f

`define ARRAY_TOP 20'hfffff
`define PAGE_MASK 20'h000ff
`define SECTOR_MASK 20'h00fff
`define HALF_BLOCK_MASK 20'h07fff
`define BLOCK_MASK 20'h0ffff
`define SECTOR_UNIT 20'h01000
`define BLOCK_UNIT 20'h10000

`define PROG_FIFO_WIDTH 8
`define PROG_FIFO_DEPTH 16
`define PROG_FIFO_ADDR_BITS 4

`endif

//--- hw/prog_data_fifo.v
// synchronous valid/ready fifo holding program data bytes
`timescale 1ns/1ps
module prog_data_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter ADDR_BITS = 4
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_BITS-1:0] wr_ptr_reg;
  reg [ADDR_BITS-1:0] rd_ptr_reg;
  reg [ADDR_BITS:0] count_reg;
  wire push;
  wire pop;

  // honest full and empty from the fill count
  assign in_ready = (count_reg != DEPTH[ADDR_BITS:0]);
  assign out_valid = (count_reg != {(ADDR_BITS+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage write
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= {ADDR_BITS{1'b0}};
      rd_ptr_reg <= {ADDR_BITS{1'b0}};
      count_reg <= {(ADDR_BITS+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

//--- hw/serial_flash_instr_frontend.v
// spi instruction front end: framing, id and status answers, protection check, command commit
// Operation
// - an erase or program whose target region touches a protected area is dropped.
// - chip select falling starts a fresh instruction and the host lowers it before clocking.
// - the first byte after chip select falls is taken as the opcode.
// - input bits are sampled on serial clock rise, most significant bit first.
// - after the opcode come address, dummy or data bytes according to the opcode.
// - chip select rising ends the instruction.
// - a read may end after any bit and leaves no trace.
// - write, program and erase act only if chip select rises on a whole byte.
// - while an internal cycle runs, all opcodes except status read low are ignored.
// - opcodes 06h, 50h and 04h set write permit, set volatile permit, clear write permit.
// - opcodes 90h, 92h and 94h return maker and part bytes, abh returns the part byte, 9fh returns maker and a part word.
// - with complement protection set, the selected region is unprotected and the rest is locked.
// - the granularity bit picks 4KB sectors when one, 64KB blocks when zero.
// - the bottom bit measures the region from the top when zero, from the bottom when one.
`timescale 1ns/1ps
`include "flash_frontend_consts.vh"
module serial_flash_instr_frontend #(
  parameter [7:0] MAKER_CODE = 8'h5a,       // arbitrary value
  parameter [7:0] PART_CODE = 8'h3c,        // arbitrary value
  parameter [15:0] PART_CODE_WORD = 16'h1234 // arbitrary value
) (
  input wire clk,
  input wire rst_n,
  input wire chip_select_n_pin,
  input wire serial_clock_pin,
  input wire serial_in_pin,
  output reg serial_out_pin,
  output reg serial_out_oe_n,
  input wire array_busy,
  input wire complement_protect_bit,
  input wire protect_granularity_bit,
  input wire protect_from_bottom_bit,
  input wire protect_level_bit2,
  input wire protect_level_bit1,
  input wire protect_level_bit0,
  input wire [7:0] status_low_byte,
  input wire [7:0] status_high_byte,
  output reg write_permit_latch,
  output reg volatile_write_permit,
  output reg [23:0] array_rd_addr,
  input wire [7:0] array_rd_data,
  output reg cmd_commit,
  output reg cmd_discard,
  output reg [7:0] cmd_opcode,
  output reg [23:0] cmd_addr,
  output reg [15:0] status_wr_data,
  output reg status_wr_both,
  output wire prog_valid,
  input wire prog_ready,
  output wire [7:0] prog_data
);
  reg [2:0] cs_sync_reg;
  reg [2:0] sck_sync_reg;
  reg [1:0] si_sync_reg;
  reg [2:0] bit_cnt_reg;
  reg [2:0] byte_cnt_reg;
  reg [6:0] shift_reg;
  reg [7:0] opcode_reg;
  reg [23:0] addr_reg;
  reg ignore_reg;
  reg out_active_reg;
  reg overrun_reg;
  reg [1:0] out_idx_reg;
  reg [7:0] tx_reg;
  reg push_reg;
  reg [7:0] push_data_reg;
  wire push_ready;
  wire cs_low;
  wire cs_fall;
  wire cs_rise;
  wire sck_rise;
  wire sck_fall;
  wire [7:0] rx_byte;
  wire [2:0] level;
  reg [7:0] next_out;
  reg [19:0] n_size;
  reg [19:0] n_lo;
  reg [19:0] n_hi;
  reg [19:0] t_mask;
  reg [19:0] t_lo;
  reg [19:0] t_hi;
  reg n_none;
  reg prot_hit;

  // opcodes followed by a three byte address
  function addressed;
    input [7:0] op;
    begin
      addressed = (op == `OP_PAGE_PROGRAM) || (op == `OP_SECTOR_ERASE) || (op == `OP_HALF_BLOCK_ERASE) ||
                  (op == `OP_BLOCK_ERASE) || (op == `OP_READ_DATA) || (op == `OP_FAST_READ) ||
                  (op == `OP_MAKER_PART_ID) || (op == `OP_MAKER_PART_ID_DUAL) ||
                  (op == `OP_MAKER_PART_ID_QUAD);
    end
  endfunction

  // opcodes that alter the array
  function array_write;
    input [7:0] op;
    begin
      array_write = (op == `OP_PAGE_PROGRAM) || (op == `OP_SECTOR_ERASE) || (op == `OP_HALF_BLOCK_ERASE) ||
                    (op == `OP_BLOCK_ERASE) || (op == `OP_CHIP_ERASE_A) || (op == `OP_CHIP_ERASE_B);
    end
  endfunction

  // count of bytes in front of the first output byte, zero when nothing is returned
  function [2:0] lead_bytes;
    input [7:0] op;
    begin
      case (op)
        `OP_STATUS_READ_LOW, `OP_STATUS_READ_HIGH, `OP_LONG_ID: lead_bytes = 3'd1;
        `OP_READ_DATA, `OP_WAKE_ID, `OP_MAKER_PART_ID,
        `OP_MAKER_PART_ID_DUAL, `OP_MAKER_PART_ID_QUAD: lead_bytes = 3'd4;
        `OP_FAST_READ: lead_bytes = 3'd5;
        default: lead_bytes = 3'd0;
      endcase
    end
  endfunction

  // pins cross into clk through two flops, a third stage feeds the edge finders
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_reg <= 3'b111;
      sck_sync_reg <= 3'b000;
      si_sync_reg <= 2'b00;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], chip_select_n_pin};
      sck_sync_reg <= {sck_sync_reg[1:0], serial_clock_pin};
      si_sync_reg <= {si_sync_reg[0], serial_in_pin};
    end
  end

  assign cs_low = ~cs_sync_reg[1];
  assign cs_fall = cs_sync_reg[2] & ~cs_sync_reg[1];
  assign cs_rise = ~cs_sync_reg[2] & cs_sync_reg[1];
  assign sck_rise = ~sck_sync_reg[2] & sck_sync_reg[1];
  assign sck_fall = sck_sync_reg[2] & ~sck_sync_reg[1];
  assign rx_byte = {shift_reg, si_sync_reg[1]};
  assign level = {protect_level_bit2, protect_level_bit1, protect_level_bit0};

  // normal protected range from level, granularity and side
  always @* begin
    n_none = (level == 3'd0);
    n_size = `BLOCK_UNIT;
    n_lo = 20'h00000;
    n_hi = `ARRAY_TOP;
    if (level == 3'd7 || (!protect_granularity_bit && level > 3'd4)) begin
      n_lo = 20'h00000;
    end else if (!n_none) begin
      if (protect_granularity_bit) begin
        n_size = `SECTOR_UNIT << ((level > 3'd4) ? 3'd3 : (level - 3'd1));
      end else begin
        n_size = `BLOCK_UNIT << (level - 3'd1);
      end
      if (protect_from_bottom_bit) begin
        n_hi = n_size - 20'h00001;
      end else begin
        n_lo = ~(n_size - 20'h00001);
      end
    end
  end

  // target region of the pending erase or program and the overlap test
  always @* begin
    case (opcode_reg)
      `OP_PAGE_PROGRAM: t_mask = `PAGE_MASK;
      `OP_SECTOR_ERASE: t_mask = `SECTOR_MASK;
      `OP_HALF_BLOCK_ERASE: t_mask = `HALF_BLOCK_MASK;
      `OP_BLOCK_ERASE: t_mask = `BLOCK_MASK;
      default: t_mask = `ARRAY_TOP;
    endcase
    t_lo = addr_reg[19:0] & ~t_mask;
    t_hi = t_lo | t_mask;
    if (complement_protect_bit) begin
      prot_hit = n_none | (t_lo < n_lo) | (t_hi > n_hi);
    end else begin
      prot_hit = ~n_none & (t_lo <= n_hi) & (t_hi >= n_lo);
    end
  end

  // byte to send next for the current opcode
  always @* begin
    case (opcode_reg)
      `OP_STATUS_READ_LOW: next_out = status_low_byte;
      `OP_STATUS_READ_HIGH: next_out = status_high_byte;
      `OP_READ_DATA, `OP_FAST_READ: next_out = array_rd_data;
      `OP_WAKE_ID: next_out = PART_CODE;
      `OP_MAKER_PART_ID, `OP_MAKER_PART_ID_DUAL, `OP_MAKER_PART_ID_QUAD:
        next_out = out_idx_reg[0] ? PART_CODE : MAKER_CODE;
      `OP_LONG_ID: begin
        case (out_idx_reg)
          2'd0: next_out = MAKER_CODE;
          2'd1: next_out = PART_CODE_WORD[15:8];
          default: next_out = PART_CODE_WORD[7:0];
        endcase
      end
      default: next_out = 8'h00;
    endcase
  end

  // instruction framing, capture, output shifting and commit at chip select rise
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 3'd0;
      byte_cnt_reg <= 3'd0;
      shift_reg <= 7'h00;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
      ignore_reg <= 1'b0;
      out_active_reg <= 1'b0;
      overrun_reg <= 1'b0;
      out_idx_reg <= 2'd0;
      tx_reg <= 8'h00;
      push_reg <= 1'b0;
      push_data_reg <= 8'h00;
      serial_out_pin <= 1'b0;
      serial_out_oe_n <= 1'b1;
      write_permit_latch <= 1'b0;
      volatile_write_permit <= 1'b0;
      array_rd_addr <= 24'h000000;
      cmd_commit <= 1'b0;
      cmd_discard <= 1'b0;
      cmd_opcode <= 8'h00;
      cmd_addr <= 24'h000000;
      status_wr_data <= 16'h0000;
      status_wr_both <= 1'b0;
    end else begin
      push_reg <= 1'b0;
      cmd_commit <= 1'b0;
      cmd_discard <= 1'b0;
      serial_out_pin <= tx_reg[7];
      serial_out_oe_n <= ~(out_active_reg & cs_low);
      if (cs_fall) begin
        bit_cnt_reg <= 3'd0;
        byte_cnt_reg <= 3'd0;
        ignore_reg <= 1'b0;
        out_active_reg <= 1'b0;
        overrun_reg <= 1'b0;
        out_idx_reg <= 2'd0;
      end else if (cs_low && sck_rise) begin
        shift_reg <= rx_byte[6:0];
        bit_cnt_reg <= bit_cnt_reg + 3'd1;
        if (bit_cnt_reg == 3'd7) begin
          if (byte_cnt_reg != 3'd7) begin
            byte_cnt_reg <= byte_cnt_reg + 3'd1;
          end
          if (byte_cnt_reg == 3'd0) begin
            opcode_reg <= rx_byte;
            ignore_reg <= array_busy && (rx_byte != `OP_STATUS_READ_LOW);
            out_active_reg <= !(array_busy && (rx_byte != `OP_STATUS_READ_LOW)) && (lead_bytes(rx_byte) == 3'd1);
          end else if (!ignore_reg) begin
            if (addressed(opcode_reg) && byte_cnt_reg <= 3'd3) begin
              addr_reg <= {addr_reg[15:0], rx_byte};
              array_rd_addr <= {addr_reg[15:0], rx_byte};
            end
            if (opcode_reg == `OP_STATUS_WRITE && byte_cnt_reg <= 3'd2) begin
              status_wr_data <= {rx_byte, status_wr_data[15:8]};
            end
            if (opcode_reg == `OP_PAGE_PROGRAM && byte_cnt_reg >= 3'd4) begin
              push_reg <= push_ready;
              push_data_reg <= rx_byte;
              if (!push_ready) begin
                overrun_reg <= 1'b1;
              end
            end
            if (lead_bytes(opcode_reg) != 3'd0 && byte_cnt_reg == lead_bytes(opcode_reg) - 3'd1) begin
              out_active_reg <= 1'b1;
            end
          end
        end
      end else if (cs_low && sck_fall && out_active_reg) begin
        if (bit_cnt_reg == 3'd0) begin
          tx_reg <= next_out;
          out_idx_reg <= (opcode_reg == `OP_LONG_ID && out_idx_reg == 2'd2) ? 2'd0 : out_idx_reg + 2'd1;
          if (opcode_reg == `OP_READ_DATA || opcode_reg == `OP_FAST_READ) begin
            array_rd_addr <= array_rd_addr + 24'h000001;
          end
        end else begin
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end else if (cs_rise) begin
        out_active_reg <= 1'b0;
        cmd_opcode <= opcode_reg;
        cmd_addr <= addr_reg;
        status_wr_both <= (byte_cnt_reg == 3'd3);
        if (!ignore_reg && bit_cnt_reg == 3'd0 && byte_cnt_reg != 3'd0) begin
          case (opcode_reg)
            `OP_WRITE_ENABLE: if (byte_cnt_reg == 3'd1) write_permit_latch <= 1'b1;
            `OP_VOLATILE_WRITE_ENABLE: if (byte_cnt_reg == 3'd1) volatile_write_permit <= 1'b1;
            `OP_WRITE_DISABLE: if (byte_cnt_reg == 3'd1) write_permit_latch <= 1'b0;
            `OP_STATUS_WRITE: begin
              if ((byte_cnt_reg == 3'd2 || byte_cnt_reg == 3'd3) && (write_permit_latch || volatile_write_permit)) begin
                cmd_commit <= 1'b1;
                write_permit_latch <= 1'b0;
                volatile_write_permit <= 1'b0;
              end
            end
            default: begin
              if (array_write(opcode_reg)) begin
                if (write_permit_latch && !prot_hit && !overrun_reg &&
                    (((opcode_reg == `OP_CHIP_ERASE_A || opcode_reg == `OP_CHIP_ERASE_B) && byte_cnt_reg == 3'd1) ||
                     (opcode_reg == `OP_PAGE_PROGRAM && byte_cnt_reg >= 3'd5) ||
                     (opcode_reg != `OP_PAGE_PROGRAM && addressed(opcode_reg) && byte_cnt_reg == 3'd4))) begin
                  cmd_commit <= 1'b1;
                  write_permit_latch <= 1'b0;
                end else begin
                  cmd_discard <= (opcode_reg == `OP_PAGE_PROGRAM);
                end
              end
            end
          endcase
        end else if (opcode_reg == `OP_PAGE_PROGRAM && byte_cnt_reg != 3'd0 && !ignore_reg) begin
          cmd_discard <= 1'b1;
        end
      end
    end
  end

  // program data buffer toward the array
  prog_data_fifo #(
    .WIDTH(`PROG_FIFO_WIDTH),
    .DEPTH(`PROG_FIFO_DEPTH),
    .ADDR_BITS(`PROG_FIFO_ADDR_BITS)
  ) u_prog_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_reg),
    .in_ready(push_ready),
    .in_data(push_data_reg),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(prog_data)
  );
endmodule

//--- tb/flash_frontend_checker.sv
// port assertions for the serial flash instruction front end
`timescale 1ns/1ps
module flash_frontend_checker (
  input wire clk,
  input wire rst_n,
  input wire chip_select_n_pin,
  input wire serial_out_oe_n,
  input wire array_busy,
  input wire write_permit_latch,
  input wire cmd_commit,
  input wire cmd_discard,
  input wire [7:0] cmd_opcode,
  input wire prog_valid,
  input wire prog_ready,
  input wire [7:0] prog_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg [10:0] busy_run_reg;
  // cycles of unbroken busy, saturating
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_run_reg <= 11'h000;
    else if (!array_busy) busy_run_reg <= 11'h000;
    else if (busy_run_reg != 11'h7ff) busy_run_reg <= busy_run_reg + 11'h001;
  end
  commit_pulse_a: assert property (cmd_commit |=> !cmd_commit) else $error("commit held");
  one_result_a: assert property (!(cmd_commit && cmd_discard)) else $error("commit with discard");
  commit_cs_a: assert property (cmd_commit |-> $past(chip_select_n_pin, 2) && $past(chip_select_n_pin, 3))
    else $error("commit inside frame");
  busy_commit_a: assert property (cmd_commit |-> busy_run_reg != 11'h7ff) else $error("commit while busy");
  commit_permit_a: assert property (cmd_commit && cmd_opcode != 8'h01 |-> $past(write_permit_latch, 4))
    else $error("commit without permit");
  read_commit_a: assert property (cmd_commit |-> !(cmd_opcode inside {8'h03, 8'h0b, 8'h05, 8'h35, 8'h9f}))
    else $error("read committed");
  oe_frame_a: assert property (!serial_out_oe_n |-> !$past(chip_select_n_pin, 7)) else $error("drive outside frame");
  fifo_hold_a: assert property (prog_valid && !prog_ready |=> prog_valid && $stable(prog_data))
    else $error("program byte not held");
endmodule
bind serial_flash_instr_frontend flash_frontend_checker chk (.clk(clk), .rst_n(rst_n),
  .chip_select_n_pin(chip_select_n_pin), .serial_out_oe_n(serial_out_oe_n), .array_busy(array_busy),
  .write_permit_latch(write_permit_latch), .cmd_commit(cmd_commit), .cmd_discard(cmd_discard),
  .cmd_opcode(cmd_opcode), .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_data(prog_data));

//--- tb/spi_host_model.sv
// spi host model: drives chip select, serial clock and serial data, captures the reply line
`timescale 1ns/1ps
module spi_host_model (
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  logic [7:0] txb [0:31];
  logic [7:0] rxb [0:31];
  // idle frame level, clock stands still between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // one frame of nbits, msb first, 40 ns per clock phase
  task automatic frame(input int nbits);
    cs_n = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++) begin
      mosi = txb[i / 8][7 - i % 8];
      #40 sclk = 1'b1;
      rxb[i / 8][7 - i % 8] = miso;
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    mosi = ~mosi; // released line must not keep the last bit
    #120;
  endtask
endmodule

//--- tb/tb.sv
// self-checking bench for the serial flash instruction front end
`timescale 1ns/1ps
`include "flash_frontend_consts.vh"
module tb;
  localparam logic [7:0] MK = 8'hc3; // arbitrary value
  localparam logic [7:0] PC = 8'h71; // arbitrary value
  localparam logic [15:0] PW = 16'h2b6e; // arbitrary value
  localparam logic [7:0] SL = 8'h9c;
  localparam logic [7:0] SH = 8'h4e;
  logic clk, rst_n, busy, prdy;
  logic [5:0] prot; // complement, granularity, from bottom, level 2..0
  wire cs_n, sck, mosi, miso, sout, oe_n, wpl, vwp, commit, discard, both, pvalid;
  wire [23:0] rd_addr, c_addr;
  wire [7:0] c_op, pdata;
  wire [15:0] swd;
  int bad_count, checks_done, commits, discards, n;
  logic [23:0] last_addr;
  logic [7:0] last_op;
  // reply rows: opcode, lead bytes less one, first two reply bytes
  logic [31:0] rtab [0:8] = '{{`OP_STATUS_READ_LOW, 8'h00, SL, SL}, {`OP_STATUS_READ_HIGH, 8'h00, SH, SH},
    {`OP_LONG_ID, 8'h00, MK, PW[15:8]}, {`OP_WAKE_ID, 8'h03, PC, PC}, {`OP_MAKER_PART_ID, 8'h03, MK, PC},
    {`OP_MAKER_PART_ID_DUAL, 8'h03, MK, PC}, {`OP_MAKER_PART_ID_QUAD, 8'h03, MK, PC},
    {`OP_READ_DATA, 8'h03, 8'hb5, 8'hb4}, {`OP_FAST_READ, 8'h04, 8'hb5, 8'hb4}};
  // protection rows: control bits, erase address, accepted
  logic [30:0] ptab [0:7] = '{{6'h21, 24'h0f1000, 1'b1}, {6'h21, 24'h0e0000, 1'b0}, {6'h20, 24'h0ff000, 1'b0},
    {6'h27, 24'h000000, 1'b1}, {6'h31, 24'h0ff000, 1'b1}, {6'h31, 24'h0fe000, 1'b0}, {6'h29, 24'h000000, 1'b1},
    {6'h29, 24'h010000, 1'b0}};
  assign miso = oe_n ? 1'bz : sout;
  spi_host_model host (.cs_n(cs_n), .sclk(sck), .mosi(mosi), .miso(miso));
  serial_flash_instr_frontend #(.MAKER_CODE(MK), .PART_CODE(PC), .PART_CODE_WORD(PW))
    serial_flash_instr_frontend_inst (.clk(clk), .rst_n(rst_n), .chip_select_n_pin(cs_n),
    .serial_clock_pin(sck), .serial_in_pin(mosi), .serial_out_pin(sout), .serial_out_oe_n(oe_n),
    .array_busy(busy), .complement_protect_bit(prot[5]), .protect_granularity_bit(prot[4]),
    .protect_from_bottom_bit(prot[3]), .protect_level_bit2(prot[2]), .protect_level_bit1(prot[1]),
    .protect_level_bit0(prot[0]), .status_low_byte(SL), .status_high_byte(SH), .write_permit_latch(wpl),
    .volatile_write_permit(vwp), .array_rd_addr(rd_addr), .array_rd_data(rd_addr[7:0] ^ 8'ha5),
    .cmd_commit(commit), .cmd_discard(discard), .cmd_opcode(c_op), .cmd_addr(c_addr), .status_wr_data(swd),
    .status_wr_both(both), .prog_valid(pvalid), .prog_ready(prdy), .prog_data(pdata));
  task automatic cmp_val(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // loads the first four bytes and runs one frame
  task automatic send(input logic [31:0] w, input int nbits);
    for (int i = 0; i < 4; i++)
      host.txb[i] = w[31 - 8 * i -: 8];
    host.frame(nbits);
  endtask
  // drains the program buffer, bytes counting up from base
  task automatic drain(input int cnt, input logic [7:0] base);
    int got;
    got = 0;
    prdy = 1'b1;
    // look at the buffer output while it is settled, the pop lands on the next edge
    for (int k = 0; k < 100; k++) begin
      if (pvalid === 1'b1) begin
        cmp_val("program byte", base + 8'(got), pdata);
        got++;
      end
      @(posedge clk);
      #1;
    end
    prdy = 1'b0;
    cmp_val("program byte count", 24'(cnt), 24'(got));
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard
  initial begin
    #600000;
    bad_count++;
    wrap_up();
  end
  // notes every committed or discarded command
  always @(posedge clk) begin
    if (commit === 1'b1) begin
      commits++;
      last_addr = c_addr;
      last_op = c_op;
    end
    if (discard === 1'b1) discards++;
  end
  initial begin
    rst_n = 1'b0;
    busy = 1'b0;
    prdy = 1'b0;
    prot = 6'h27;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    cmp_val("oe after reset", 24'h1, oe_n);
    cmp_val("permit after reset", 24'h0, wpl);
    repeat (4) @(posedge clk);
    #1;
    for (int r = 0; r < 9; r++) begin
      send({rtab[r][31:24], 24'h000010}, 8 * (rtab[r][23:16] + 3));
      cmp_val("reply first", rtab[r][15:8], host.rxb[rtab[r][23:16] + 1]);
      cmp_val("reply second", rtab[r][7:0], host.rxb[rtab[r][23:16] + 2]);
    end
    cmp_val("reads commit", 24'h0, 24'(commits));
    $display("test replies done");
    for (int r = 0; r < 8; r++) begin
      prot = ptab[r][30:25];
      send({`OP_WRITE_ENABLE, 24'h0}, 8);
      n = commits;
      send({`OP_SECTOR_ERASE, ptab[r][24:1]}, 32);
      cmp_val("erase accepted", 24'(ptab[r][0]), 24'(commits - n));
      if (ptab[r][0]) cmp_val("erase address", ptab[r][24:1], last_addr);
    end
    $display("test protection done");
    cmp_val("permit kept", 24'h1, wpl);
    send({`OP_WRITE_DISABLE, 24'h0}, 8);
    cmp_val("permit cleared", 24'h0, wpl);
    send({`OP_WRITE_ENABLE, 24'h0}, 7);
    cmp_val("partial enable", 24'h0, wpl);
    send({`OP_VOLATILE_WRITE_ENABLE, 24'h0}, 8);
    cmp_val("volatile permit", 24'h1, vwp);
    send({`OP_WRITE_ENABLE, 24'h0}, 8);
    n = commits;
    send({`OP_SECTOR_ERASE, 24'h000000}, 31);
    cmp_val("partial erase", 24'h0, 24'(commits - n));
    send({`OP_STATUS_WRITE, 24'h3a5c00}, 24);
    cmp_val("status commit", 24'h1, 24'(commits - n));
    cmp_val("status data", 24'h5c3a, swd);
    cmp_val("status pair", 24'h1, both);
    $display("test permits done");
    n = commits;
    send({`OP_READ_DATA, 24'h000010}, 13);
    send({`OP_STATUS_READ_LOW, 24'h0}, 16);
    cmp_val("read after abort", SL, host.rxb[1]);
    cmp_val("abort commit", 24'h0, 24'(commits - n));
    send({`OP_WRITE_ENABLE, 24'h0}, 8);
    busy = 1'b1;
    repeat (2100) @(posedge clk);
    #1;
    n = commits;
    send({`OP_WRITE_DISABLE, 24'h0}, 8);
    cmp_val("disable while busy", 24'h1, wpl);
    send({`OP_SECTOR_ERASE, 24'h000000}, 32);
    cmp_val("erase while busy", 24'h0, 24'(commits - n));
    send({`OP_STATUS_READ_LOW, 24'h0}, 16);
    cmp_val("status while busy", SL, host.rxb[1]);
    busy = 1'b0;
    $display("test abort and busy done");
    prot = 6'h27;
    send({`OP_WRITE_ENABLE, 24'h0}, 8);
    for (int i = 0; i < 20; i++)
      host.txb[4 + i] = 8'h10 + 8'(i);
    n = discards;
    send({`OP_PAGE_PROGRAM, 24'h000100}, 192);
    cmp_val("overrun discard", 24'h1, 24'(discards - n));
    drain(16, 8'h10);
    send({`OP_WRITE_ENABLE, 24'h0}, 8);
    n = commits;
    send({`OP_PAGE_PROGRAM, 24'h000200}, 48);
    cmp_val("program commit", 24'h1, 24'(commits - n));
    cmp_val("program opcode", `OP_PAGE_PROGRAM, last_op);
    cmp_val("program address", 24'h000200, last_addr);
    drain(2, 8'h10);
    $display("test program done");
    // reset in mid-run drops the permit and the frame logic recovers
    send({`OP_WRITE_ENABLE, 24'h0}, 8);
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    cmp_val("permit in reset", 24'h0, wpl);
    cmp_val("oe in reset", 24'h1, oe_n);
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    send({`OP_STATUS_READ_LOW, 24'h0}, 16);
    cmp_val("status after reset", SL, host.rxb[1]);
    $display("test reset done");
    wrap_up();
  end
endmodule
